/* File: src/mrtr_pkg.sv */
// constants and types shared by the monitor result and trim register bank
package mrtr_pkg;
    localparam logic [7:0] ADDR_THERM2_HIGH = 8'h2e;
    localparam logic [7:0] ADDR_THERM2_LOW = 8'h2f;
    localparam logic [7:0] ADDR_THERM3_HIGH = 8'h30;
    localparam logic [7:0] ADDR_THERM3_LOW = 8'h31;
    localparam logic [7:0] ADDR_CHARGE_HIGH = 8'h32;
    localparam logic [7:0] ADDR_CHARGE_LOW = 8'h33;
    localparam logic [7:0] ADDR_GAIN_UPPER = 8'h50;
    localparam logic [7:0] ADDR_OFFSET_TRIM = 8'h51;
    localparam logic [7:0] ADDR_GAIN_LOWER = 8'h59;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // field positions and result widths
    localparam int GAIN_UPPER_LSB = 2;
    localparam int GAIN_LOWER_LSB = 5;
    localparam int THERM_WIDTH = 14;
    localparam int CHARGE_WIDTH = 16;
    // serial target address, value is arbitrary
    localparam logic [6:0] TARGET_ADDR = 7'h08;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    // timing
    localparam int CLK_HZ = 10_000_000;
    localparam int TIMELINE_MS = 250;
    localparam int TIMELINE_CYCLES = TIMELINE_MS * (CLK_HZ / 1000);
    localparam int ALERT_SETTLE_US = 250;
    localparam int ALERT_SETTLE_CYCLES =
        (ALERT_SETTLE_US * (CLK_HZ / 1000) + 999) / 1000;
    localparam int NUM_GROUPS = 3;
    localparam logic [11:0] SETTLE_RESET = 12'h000;
    localparam logic [21:0] TIMELINE_RESET = 22'h000000;

    typedef enum {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
        ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
    } mrtr_state_t;

    typedef enum logic [1:0] {
        PAIR_NONE, PAIR_THERM2, PAIR_THERM3, PAIR_CHARGE
    } mrtr_pair_t;
endpackage

/* File: src/mrtr_pin_filter.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module mrtr_pin_filter (
    input wire logic sys_clk, // system clock
    input wire logic rst, // async reset, active high
    input wire logic pinIn, // raw asynchronous pin
    output logic level // filtered level
);
    logic stage1;
    logic stage2;
    logic stage3;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stage1 <= 1'b1;
            stage2 <= 1'b1;
            stage3 <= 1'b1;
        end else begin
            stage1 <= pinIn;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // a change counts only once two later stages agree
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            level <= 1'b1;
        end else if (stage2 == stage3) begin
            level <= stage3;
        end
    end
endmodule
`default_nettype wire

/* File: src/mrtr_result_regs.sv */
// read-only result and trim registers behind the two-wire target
`timescale 1ns/1ps
`default_nettype none
module mrtr_result_regs #(
    parameter int TIMELINE_CYCLES = mrtr_pkg::TIMELINE_CYCLES
) (
    input wire logic sys_clk, // system clock, 10 MHz
    input wire logic rst, // async reset, active high
    input wire logic sclIn, // serial clock pin
    input wire logic sdaIn, // serial data pin level
    output logic sdaOut, // serial data drive value, always low
    output logic sdaOe, // serial data pulled low while high
    input wire logic [13:0] therm2Result, // second thermistor conversion
    input wire logic therm2Valid, // one-cycle strobe for therm2Result
    input wire logic [13:0] therm3Result, // third thermistor conversion
    input wire logic therm3Valid, // one-cycle strobe for therm3Result
    input wire logic [15:0] chargeResult, // charge counter conversion
    input wire logic chargeValid, // one-cycle strobe for chargeResult
    input wire logic [4:0] gainTrimCode, // factory gain trim strap
    input wire logic [7:0] offsetTrimCode, // factory offset trim strap
    input wire logic alertRequest, // internal alert condition
    input wire logic alertIn, // alert pin level
    output logic alertOut, // alert drive value
    output logic alertOe, // alert drive enable
    output logic alertSeen, // settled sampled alert level
    output logic [2:0] groupTick // per-group timeline start pulse
);
    logic sclLevel;
    logic sdaLevel;
    logic alertLevel;
    logic sclPrev;
    logic sdaPrev;
    logic [13:0] therm2;
    logic [13:0] therm3;
    logic [15:0] charge;
    logic [4:0] gainTrim;
    logic [7:0] offsetTrim;
    logic trimLoaded;
    mrtr_pkg::mrtr_state_t state;
    logic [3:0] bitCnt;
    logic [7:0] shiftReg;
    logic [7:0] ptr;
    logic [7:0] txByte;
    logic [7:0] shadowLow;
    mrtr_pkg::mrtr_pair_t shadowPair;
    logic readMode;
    logic [11:0] settleCnt;
    logic [21:0] groupCnt [mrtr_pkg::NUM_GROUPS];

    mrtr_pin_filter sclFilter (.sys_clk(sys_clk), .rst(rst),
        .pinIn(sclIn), .level(sclLevel));
    mrtr_pin_filter sdaFilter (.sys_clk(sys_clk), .rst(rst),
        .pinIn(sdaIn), .level(sdaLevel));
    mrtr_pin_filter alertFilter (.sys_clk(sys_clk), .rst(rst),
        .pinIn(alertIn), .level(alertLevel));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] liveByte(input logic [7:0] a,
        input logic [13:0] t2, input logic [13:0] t3,
        input logic [15:0] c, input logic [4:0] g, input logic [7:0] o);
        case (a)
            mrtr_pkg::ADDR_THERM2_HIGH: liveByte = {2'h0, t2[13:8]};
            mrtr_pkg::ADDR_THERM2_LOW: liveByte = t2[7:0];
            mrtr_pkg::ADDR_THERM3_HIGH: liveByte = {2'h0, t3[13:8]};
            mrtr_pkg::ADDR_THERM3_LOW: liveByte = t3[7:0];
            mrtr_pkg::ADDR_CHARGE_HIGH: liveByte = c[15:8];
            mrtr_pkg::ADDR_CHARGE_LOW: liveByte = c[7:0];
            mrtr_pkg::ADDR_GAIN_UPPER: liveByte = {4'h0, g[4:3], 2'h0};
            mrtr_pkg::ADDR_OFFSET_TRIM: liveByte = o;
            mrtr_pkg::ADDR_GAIN_LOWER: liveByte = {g[2:0], 5'h00};
            default: liveByte = mrtr_pkg::UNMAPPED_READ;
        endcase
    endfunction

    function automatic mrtr_pkg::mrtr_pair_t pairOf(input logic [7:0] a);
        case (a)
            mrtr_pkg::ADDR_THERM2_HIGH,
            mrtr_pkg::ADDR_THERM2_LOW: pairOf = mrtr_pkg::PAIR_THERM2;
            mrtr_pkg::ADDR_THERM3_HIGH,
            mrtr_pkg::ADDR_THERM3_LOW: pairOf = mrtr_pkg::PAIR_THERM3;
            mrtr_pkg::ADDR_CHARGE_HIGH,
            mrtr_pkg::ADDR_CHARGE_LOW: pairOf = mrtr_pkg::PAIR_CHARGE;
            default: pairOf = mrtr_pkg::PAIR_NONE;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // live results; conversions never stall behind a host read
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            therm2 <= 14'h0000;
            therm3 <= 14'h0000;
            charge <= 16'h0000;
        end else begin
            if (therm2Valid) therm2 <= therm2Result;
            if (therm3Valid) therm3 <= therm3Result;
            if (chargeValid) charge <= chargeResult;
        end
    end

    // straps caught after release, never through the async reset
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            gainTrim <= 5'h00;
            offsetTrim <= 8'h00;
            trimLoaded <= 1'b0;
        end else if (!trimLoaded) begin
            gainTrim <= gainTrimCode;
            offsetTrim <= offsetTrimCode;
            trimLoaded <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    logic loadByte;
    logic [7:0] next_tx;
    logic [7:0] loadPtr;
    logic [7:0] lowShadowValue;

    assign sclRise = sclLevel && !sclPrev;
    assign sclFall = !sclLevel && sclPrev;
    assign startCond = sclLevel && sclPrev && sdaPrev && !sdaLevel;
    assign stopCond = sclLevel && sclPrev && !sdaPrev && sdaLevel;
    assign loadByte = sclFall && ((state == mrtr_pkg::ST_ADDR_ACK && readMode)
        || (state == mrtr_pkg::ST_RDATA_ACK && !shiftReg[0]));
    // after a data byte the load address is the pointer plus one
    assign loadPtr = (state == mrtr_pkg::ST_RDATA_ACK) ? ptr + 8'h01 : ptr;

    always_comb begin
        next_tx = liveByte(loadPtr, therm2, therm3, charge, gainTrim,
            offsetTrim);
        // low byte answered from the copy taken with its high byte
        if (loadPtr[0] && pairOf(loadPtr) != mrtr_pkg::PAIR_NONE
            && shadowPair == pairOf(loadPtr)) begin
            next_tx = shadowLow;
        end
        lowShadowValue = liveByte(loadPtr | 8'h01, therm2, therm3, charge,
            gainTrim, offsetTrim);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclPrev <= sclLevel;
            sdaPrev <= sdaLevel;
        end
    end

    // coherent snapshot of a result pair, dropped at start and stop
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            shadowLow <= mrtr_pkg::RESULT_RESET;
            shadowPair <= mrtr_pkg::PAIR_NONE;
        end else if (startCond || stopCond) begin
            shadowPair <= mrtr_pkg::PAIR_NONE;
        end else if (loadByte) begin
            if (!loadPtr[0] && pairOf(loadPtr) != mrtr_pkg::PAIR_NONE) begin
                shadowLow <= lowShadowValue;
                shadowPair <= pairOf(loadPtr);
            end else begin
                shadowPair <= mrtr_pkg::PAIR_NONE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // target state machine; writes are acknowledged but store nothing
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= mrtr_pkg::ST_IDLE;
            bitCnt <= 4'h0;
            shiftReg <= 8'h00;
            ptr <= 8'h00;
            txByte <= 8'h00;
            readMode <= 1'b0;
            sdaOe <= 1'b0;
            sdaOut <= 1'b0;
        end else if (startCond) begin
            state <= mrtr_pkg::ST_ADDR;
            bitCnt <= 4'h0;
            sdaOe <= 1'b0;
        end else if (stopCond) begin
            state <= mrtr_pkg::ST_IDLE;
            sdaOe <= 1'b0;
        end else if (sclRise) begin
            shiftReg <= {shiftReg[6:0], sdaLevel};
            bitCnt <= bitCnt + 4'h1;
        end else if (sclFall) begin
            case (state)
                mrtr_pkg::ST_ADDR: if (bitCnt == mrtr_pkg::BYTE_BITS) begin
                    if (shiftReg[7:1] == mrtr_pkg::TARGET_ADDR) begin
                        state <= mrtr_pkg::ST_ADDR_ACK;
                        readMode <= shiftReg[0];
                        sdaOe <= 1'b1;
                    end else begin
                        state <= mrtr_pkg::ST_IDLE;
                    end
                end
                mrtr_pkg::ST_ADDR_ACK, mrtr_pkg::ST_RDATA_ACK: begin
                    bitCnt <= 4'h0;
                    if (loadByte) begin
                        state <= mrtr_pkg::ST_RDATA;
                        ptr <= loadPtr;
                        txByte <= next_tx;
                        sdaOe <= !next_tx[7];
                    end else if (state == mrtr_pkg::ST_ADDR_ACK) begin
                        state <= mrtr_pkg::ST_PTR;
                        sdaOe <= 1'b0;
                    end else begin
                        state <= mrtr_pkg::ST_IDLE; // host refused more
                        sdaOe <= 1'b0;
                    end
                end
                mrtr_pkg::ST_PTR, mrtr_pkg::ST_WDATA:
                    if (bitCnt == mrtr_pkg::BYTE_BITS) begin
                        if (state == mrtr_pkg::ST_PTR) begin
                            ptr <= shiftReg;
                            state <= mrtr_pkg::ST_PTR_ACK;
                        end else begin
                            ptr <= ptr + 8'h01;
                            state <= mrtr_pkg::ST_WDATA_ACK;
                        end
                        sdaOe <= 1'b1;
                    end
                mrtr_pkg::ST_PTR_ACK, mrtr_pkg::ST_WDATA_ACK: begin
                    state <= mrtr_pkg::ST_WDATA;
                    bitCnt <= 4'h0;
                    sdaOe <= 1'b0;
                end
                mrtr_pkg::ST_RDATA: if (bitCnt == mrtr_pkg::BYTE_BITS) begin
                    state <= mrtr_pkg::ST_RDATA_ACK;
                    sdaOe <= 1'b0;
                end else begin
                    sdaOe <= !txByte[3'(7 - bitCnt)];
                end
                default: state <= mrtr_pkg::ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // free-running timelines of equal period, reset together, so the groups stay in step
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < mrtr_pkg::NUM_GROUPS; i++) begin
                groupCnt[i] <= mrtr_pkg::TIMELINE_RESET;
            end
            groupTick <= 3'h0;
        end else begin
            for (int i = 0; i < mrtr_pkg::NUM_GROUPS; i++) begin
                groupTick[i] <= (groupCnt[i] == 22'h000000);
                if (groupCnt[i] == 22'(TIMELINE_CYCLES - 1)) begin
                    groupCnt[i] <= mrtr_pkg::TIMELINE_RESET;
                end else begin
                    groupCnt[i] <= groupCnt[i] + 22'h000001;
                end
            end
        end
    end

    // after release the line needs time to fall before it is trusted
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            alertOe <= 1'b0;
            alertOut <= 1'b0;
            alertSeen <= 1'b0;
            settleCnt <= mrtr_pkg::SETTLE_RESET;
        end else begin
            alertOe <= alertRequest;
            alertOut <= alertRequest;
            if (alertRequest) begin
                settleCnt <= 12'(mrtr_pkg::ALERT_SETTLE_CYCLES);
                alertSeen <= 1'b1;
            end else if (settleCnt != mrtr_pkg::SETTLE_RESET) begin
                settleCnt <= settleCnt - 12'h001;
            end else begin
                alertSeen <= alertLevel;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_therm2_coherent: assert property (loadByte
        && loadPtr == mrtr_pkg::ADDR_THERM2_HIGH |=>
        shadowPair == mrtr_pkg::PAIR_THERM2
        && shadowLow == $past(therm2[7:0]))
        else $error("therm2 low byte not captured");
    a_therm3_coherent: assert property (loadByte
        && loadPtr == mrtr_pkg::ADDR_THERM3_HIGH |=>
        shadowPair == mrtr_pkg::PAIR_THERM3
        && shadowLow == $past(therm3[7:0]))
        else $error("therm3 low byte not captured");
    a_charge_coherent: assert property (loadByte
        && loadPtr == mrtr_pkg::ADDR_CHARGE_LOW
        && shadowPair == mrtr_pkg::PAIR_CHARGE |=> txByte == $past(shadowLow))
        else $error("charge low byte not from snapshot");
    a_therm_high_zero: assert property (loadByte
        && (loadPtr == mrtr_pkg::ADDR_THERM2_HIGH
        || loadPtr == mrtr_pkg::ADDR_THERM3_HIGH) |=> txByte[7:6] == 2'h0)
        else $error("thermistor high byte top bits set");
    a_gain_split: assert property (loadByte
        && loadPtr == mrtr_pkg::ADDR_GAIN_LOWER |=>
        txByte == {gainTrim[2:0], 5'h00})
        else $error("gain lower field misplaced");
    a_offset_strap: assert property ($rose(trimLoaded) |->
        offsetTrim == $past(offsetTrimCode))
        else $error("offset trim not captured");
    a_group_period: assert property (groupCnt[1] == 22'h000000 |=>
        groupTick[1] ##1 !groupTick[1])
        else $error("group timeline tick wrong");
    a_alert_settle: assert property ($fell(alertRequest) |=>
        (alertSeen && $stable(settleCnt) == 1'b0) [*8])
        else $error("alert sampled before settling");

    c_therm2_pair: cover property (loadByte
        && loadPtr == mrtr_pkg::ADDR_THERM2_LOW
        && shadowPair == mrtr_pkg::PAIR_THERM2);
    c_charge_pair: cover property (loadByte
        && loadPtr == mrtr_pkg::ADDR_CHARGE_LOW
        && shadowPair == mrtr_pkg::PAIR_CHARGE);
    c_pointer_write: cover property (state == mrtr_pkg::ST_PTR_ACK);
    c_alert_release: cover property ($fell(alertOe));
endmodule
`default_nettype wire

/* File: dv/mrtr_host_model.sv */
// two-wire host model that reads and writes the register bank
`timescale 1ns/1ps
`default_nettype none
module mrtr_host_model (
    input wire logic sys_clk, // system clock
    input wire logic sdaLine, // resolved data wire
    output var logic sclOut, // serial clock, idles high
    output var logic sdaLow, // high while the host pulls data low
    output var logic [3:0] rxCount // bytes taken in the current read
);
    initial begin
        sclOut = 1'b1;
        sdaLow = 1'b0;
        rxCount = 4'h0;
    end

    // third of a bit of 8 cycles keeps every phase above the pin filter delay
    task automatic step(input logic s, input logic l);
        @(posedge sys_clk);
        sclOut <= s;
        sdaLow <= l;
        repeat (7) @(posedge sys_clk);
    endtask

    // data only moves while the clock is low, so no false start or stop
    task automatic bitOut(input logic b);
        step(1'b0, sdaLow);
        step(1'b0, !b);
        step(1'b1, !b);
    endtask

    task automatic bitIn(output logic b);
        step(1'b0, sdaLow);
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        b = sdaLine;
    endtask

    // also serves as repeated start
    task automatic startCond();
        step(1'b0, sdaLow);
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
    endtask

    task automatic stopCond();
        step(1'b0, sdaLow);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask

    task automatic sendByte(input logic [7:0] b, output logic ack);
        logic v;
        for (int i = 7; i >= 0; i--)
            bitOut(b[i]);
        bitIn(v);
        ack = !v;
    endtask

    task automatic recvByte(input logic last, output logic [7:0] d);
        logic v;
        for (int i = 7; i >= 0; i--) begin
            bitIn(v);
            d[i] = v;
        end
        bitOut(last);
        rxCount <= rxCount + 4'h1;
    endtask

    task automatic writeBus(input logic [6:0] addr, input logic [7:0] ptr,
            input logic [7:0] data, output logic ok);
        logic a;
        startCond();
        sendByte({addr, 1'b0}, ok);
        sendByte(ptr, a);
        ok = ok & a;
        sendByte(data, a);
        ok = ok & a;
        stopCond();
    endtask

    // high and low bytes come back in one burst transfer
    task automatic readRegs(input logic [7:0] ptr, input int n,
            output logic [31:0] val, output logic ok);
        logic a;
        logic [7:0] d;
        val = 32'h0;
        rxCount <= 4'h0;
        startCond();
        sendByte({mrtr_pkg::TARGET_ADDR, 1'b0}, ok);
        sendByte(ptr, a);
        ok = ok & a;
        startCond();
        sendByte({mrtr_pkg::TARGET_ADDR, 1'b1}, a);
        ok = ok & a;
        for (int i = 0; i < n; i++) begin
            recvByte(i == n - 1, d);
            val = {val[23:0], d};
        end
        stopCond();
    endtask
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// self-checking bench for the result and trim register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [4:0] GAIN_SET [2] = '{5'h1b, 5'h04};
    localparam logic [7:0] OFFSET_SET [2] = '{8'h80, 8'h7f};
    localparam int OFFSET_MV [2] = '{-128, 127};
    localparam logic [7:0] PAIR_ADDR [3] = '{mrtr_pkg::ADDR_THERM2_HIGH,
        mrtr_pkg::ADDR_THERM3_HIGH, mrtr_pkg::ADDR_CHARGE_HIGH};
    localparam logic [15:0] OLD_VAL [3] = '{16'hff5a, 16'hc0a5, 16'h7ffe};
    localparam logic [15:0] NEW_VAL [3] = '{16'h0123, 16'h3e81, 16'h8001};
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic alertReq = 1'b0;
    logic extAlert = 1'b0;
    logic [15:0] resData = 16'h0000;
    logic [2:0] validVec = 3'h0;
    logic [4:0] gainCode = GAIN_SET[0];
    logic [7:0] offsetCode = OFFSET_SET[0];
    logic sclWire, hostLow, sdaOut, sdaOe, alertOut, alertOe, alertSeen;
    logic [2:0] groupTick;
    logic [3:0] hostRx;
    int failCount = 0;
    int comparisons = 0;
    // pull-up on data, pull-down on alert when nobody drives
    wire sdaWire = !(hostLow || (sdaOe && !sdaOut));
    wire alertWire = alertOe ? alertOut : extAlert;

    mrtr_result_regs #(.TIMELINE_CYCLES(64)) i_dut (
        .sys_clk(sys_clk), .rst(rst), .sclIn(sclWire), .sdaIn(sdaWire),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .therm2Result(resData[13:0]),
        .therm2Valid(validVec[0]), .therm3Result(resData[13:0]),
        .therm3Valid(validVec[1]), .chargeResult(resData),
        .chargeValid(validVec[2]), .gainTrimCode(gainCode),
        .offsetTrimCode(offsetCode), .alertRequest(alertReq),
        .alertIn(alertWire), .alertOut(alertOut), .alertOe(alertOe),
        .alertSeen(alertSeen), .groupTick(groupTick)
    );
    mrtr_host_model i_host (
        .sys_clk(sys_clk), .sdaLine(sdaWire), .sclOut(sclWire),
        .sdaLow(hostLow), .rxCount(hostRx)
    );

    always #50 sys_clk = ~sys_clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failCount++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask

    task automatic summarize();
        if (failCount == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // the three result buses share one data source, strobes pick the target
    task automatic loadResult(input int p, input logic [15:0] v);
        @(posedge sys_clk);
        resData <= v;
        validVec <= 3'b001 << p;
        @(posedge sys_clk);
        validVec <= 3'b000;
    endtask

    initial begin
        repeat (60000) @(posedge sys_clk);
        failCount++;
        summarize();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] v;
        logic [31:0] w;
        logic ok;
        logic [31:0] ticks [3];
        logic [15:0] mask;
        // second pass is a mid-run reset with other trim straps
        for (int k = 0; k < 2; k++) begin
            @(posedge sys_clk);
            rst <= 1'b1;
            gainCode <= GAIN_SET[k];
            offsetCode <= OFFSET_SET[k];
            repeat (15) @(posedge sys_clk);
            rst <= 1'b0;
            repeat (4) @(posedge sys_clk);
            i_host.readRegs(mrtr_pkg::ADDR_THERM3_HIGH, 4, v, ok);
            check(v, 32'h0);
            i_host.readRegs(mrtr_pkg::ADDR_GAIN_UPPER, 2, v, ok);
            i_host.readRegs(mrtr_pkg::ADDR_GAIN_LOWER, 1, w, ok);
            check(v[15:8], 32'({4'h0, GAIN_SET[k][4:3], 2'b00}));
            check(w, 32'({GAIN_SET[k][2:0], 5'h00}));
            check(32'(365 + {v[11:10], w[7:5]}), 32'(365 + GAIN_SET[k]));
            check(32'($signed(v[7:0])), 32'(OFFSET_MV[k]));
            check(32'(ok), 32'h1);
            if (k == 0) begin
                for (int p = 0; p < 3; p++) begin
                    mask = (p < 2) ? 16'h3fff : 16'hffff;
                    loadResult(p, OLD_VAL[p]);
                    // new value lands between the high and low byte
                    fork
                        i_host.readRegs(PAIR_ADDR[p], 2, v, ok);
                        begin
                            @(posedge sys_clk);
                            wait (hostRx == 4'h1);
                            loadResult(p, NEW_VAL[p]);
                        end
                    join
                    check(v, 32'(OLD_VAL[p] & mask));
                    i_host.readRegs(PAIR_ADDR[p], 2, v, ok);
                    check(v, 32'(NEW_VAL[p] & mask));
                end
                check(32'($signed(v[15:0])), 32'(-32767));
                i_host.writeBus(mrtr_pkg::TARGET_ADDR, PAIR_ADDR[0], 8'hff, ok);
                check(32'(ok), 32'h1);
                i_host.writeBus(mrtr_pkg::TARGET_ADDR ^ 7'h01, PAIR_ADDR[0],
                    8'hff, ok);
                check(32'(ok), 32'h0);
                i_host.readRegs(PAIR_ADDR[0], 2, v, ok);
                check(v, 32'(NEW_VAL[0] & 16'h3fff));
                i_host.readRegs(8'h40, 1, v, ok);
                check(v, 32'(mrtr_pkg::UNMAPPED_READ));
                alertReq <= 1'b1;
                repeat (3) @(negedge sys_clk);
                check(32'({alertOe, alertOut, alertSeen}), 32'h7);
                @(posedge sys_clk);
                alertReq <= 1'b0;
                repeat (2000) @(negedge sys_clk);
                check(32'(alertSeen), 32'h1);
                repeat (600) @(negedge sys_clk);
                check(32'({alertOe, alertSeen}), 32'h0);
                @(posedge sys_clk);
                extAlert <= 1'b1;
                repeat (10) @(negedge sys_clk);
                check(32'(alertSeen), 32'h1);
                @(posedge sys_clk);
                extAlert <= 1'b0;
                ticks = '{32'h0, 32'h0, 32'h0};
                repeat (640) begin
                    @(negedge sys_clk);
                    for (int g = 0; g < 3; g++)
                        ticks[g] += 32'(groupTick[g]);
                end
                for (int g = 0; g < 3; g++)
                    check(ticks[g], 32'd10);
            end
        end
        summarize();
    end
endmodule
`default_nettype wire
